/* core/dprf_defines.svh */
`ifndef DPRF_DEFINES_SVH
`define DPRF_DEFINES_SVH
// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define DPRF_A_CTRL    8'h00
`define DPRF_A_SRC0    8'h04
`define DPRF_A_SRC1    8'h08
`define DPRF_A_STAT    8'h0C
`define DPRF_A_DCMD    8'h10
`define DPRF_C_EOI     0
`define DPRF_C_BDM     1
`define DPRF_C_FRAG4   2
`define DPRF_C_MUTE    3
`define DPRF_C_SRC     4
`define DPRF_C_PA_LO   8
`define DPRF_C_PA_HI   11
`define DPRF_SRC_HI    8
// ----------------------------------------
// command lengths and counts
// ----------------------------------------
`define DPRF_LEN_BCAST 6'h01
`define DPRF_LEN_F2    6'h02
`define DPRF_LEN_F4    6'h04
`define DPRF_CMD_BITS  6'h20
`define DPRF_READS_F2  4'h8
`define DPRF_READS_F4  4'h4
`define DPRF_CMD_READ  4'h0
`define DPRF_CRM_SEED  8'h00
`define DPRF_PA_GLOBAL 4'h0
// ----------------------------------------
// frame fields and crc
// ----------------------------------------
`define DPRF_W_ID      5'h04
`define DPRF_W_KAC     5'h02
`define DPRF_W_ST      5'h04
`define DPRF_W_DAT     5'h0A
`define DPRF_W_CRC     5'h08
`define DPRF_MSG_W     5'h14
`define DPRF_CMD_W     5'h18
`define DPRF_POLY      8'h2F
`define DPRF_ERR_UNS   10'h3FF
`define DPRF_ERR_SGN   10'h200
// ----------------------------------------
// status codes
// ----------------------------------------
`define DPRF_S_NORMAL  4'h0
`define DPRF_S_UNLOCK  4'h1
`define DPRF_S_SELFT   4'h2
`define DPRF_S_OSC     4'h3
`define DPRF_S_PRESS   4'h4
`define DPRF_S_TEMP    4'h5
`define DPRF_S_UOTP    4'h8
`define DPRF_S_URW     4'h9
`define DPRF_S_FOTP    4'hA
`define DPRF_S_TEST    4'hB
`define DPRF_S_SUPPLY  4'hC
`define DPRF_S_RESET   4'hD
`endif

/* core/dprf_pkg.sv */
package dprf_pkg;
  typedef enum logic [0:0] {
    DPRF_IDLE = 1'b0,
    DPRF_CRC  = 1'b1
  } dprf_state_t;

  typedef struct packed {
    logic       signed_en;
    logic       dsel;
    logic [2:0] fmt;
    logic [3:0] ident;
  } dprf_src_t;

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [4:0]  cnt;
    logic [19:0] sh;
    logic [7:0]  crc;
  } dprf_crc_st_t;
endpackage : dprf_pkg

/* core/dprf_crc_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface dprf_crc_if;
  logic        go;
  logic [19:0] msg;
  logic [4:0]  len;
  logic [7:0]  seed;
  logic        done;
  logic [7:0]  crc;
  modport req (output go, msg, len, seed, input done, crc);
  modport eng (input go, msg, len, seed, output done, crc);
endinterface : dprf_crc_if
`default_nettype wire

/* core/dprf_crc_unit.sv */
`include "dprf_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module dprf_crc_unit (
  input  wire logic  mclk,
  input  wire logic  reset_n,
  input  wire logic  ce,
  dprf_crc_if.eng    cif
);
  dprf_pkg::dprf_crc_st_t st_ff;
  dprf_pkg::dprf_crc_st_t nxt_st;

  // ----------------------------------------
  // serial shift, message msb first then zeros
  // ----------------------------------------
  // the message arrives left-justified, so shifting it out already
  // feeds the eight trailing zeros with no extra logic
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    if (cif.go) begin
      nxt_st.busy = 1'b1;
      nxt_st.sh   = cif.msg;
      nxt_st.crc  = cif.seed;
      nxt_st.cnt  = cif.len + `DPRF_W_CRC;
    end else if (st_ff.busy) begin
      nxt_st.crc = {st_ff.crc[6:0], st_ff.sh[19]}
                   ^ (st_ff.crc[7] ? `DPRF_POLY : 8'h00);
      nxt_st.sh  = {st_ff.sh[18:0], 1'b0};
      nxt_st.cnt = st_ff.cnt - 5'h01;
      if (st_ff.cnt == 5'h01) begin
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign cif.done = st_ff.done;
  assign cif.crc  = st_ff.crc;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  property p_crc_len;
    ce && cif.go |=> st_ff.busy [*8];
  endproperty
  a_crc_len: assert property (p_crc_len) else $error("crc ended early");
endmodule : dprf_crc_unit
`default_nettype wire

/* core/dprf_top.sv */
// Contract
// - modes enable only after end-of-init lock set
// - in collection mode decode reads and fragments
// - diag off: answer only one-bit broadcast reads
// - diag fragments are 2 or 4 bits
// - diag on: answer reads and fragments only
// - read or any non-fragment length clears diag assembly
// - diag answer only after valid 32 bits
// - diag command checked like normal commands
// - broadcast read accepted without any check
// - send periodic frame on read or fragment
// - frame fields ordered, chosen by format field
// - source id field holds 4-bit identifier
// - 2-bit keep-alive counter per source, from 00
// - sensor data chosen by data type select
// - frame ends with 8-bit crc
// - crc serial, msb first, eight zeros after
// - crc polynomial fixed, seed is source id
// - low status codes keep data unless no status field
// - high status codes replace data with error
// - muted supply error suppresses the frame
// - any signed source uses signed error code
// - four or eight reads carry diag answer
`include "dprf_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module dprf_top (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        cmd_valid,
  input  wire logic [5:0]  cmd_len,
  input  wire logic [3:0]  cmd_bits,
  input  wire logic [9:0]  pressure_data,
  input  wire logic [9:0]  temperature_data,
  input  wire logic        user_array_unlocked,
  input  wire logic        selftest_incomplete,
  input  wire logic        selftest_running,
  input  wire logic        selftest_fault,
  input  wire logic        device_status_osc,
  input  wire logic        pressure_over_range,
  input  wire logic        pressure_under_range,
  input  wire logic        pressure_redundancy_mismatch,
  input  wire logic        temperature_error,
  input  wire logic        user_otp_error,
  input  wire logic        user_rw_error,
  input  wire logic        factory_otp_error,
  input  wire logic        test_mode_active,
  input  wire logic        device_status_supply,
  input  wire logic        reset_occurred_flag,
  input  wire logic [31:0] diag_resp_word,
  output logic             frame_valid,
  output logic      [27:0] frame_data,
  output logic      [4:0]  frame_len,
  output logic             diag_frag_valid,
  output logic      [7:0]  diag_frag,
  output logic             diag_cmd_valid,
  output logic      [31:0] diag_cmd_word,
  output logic             periodic_collection_mode
);
  typedef struct packed {
    dprf_pkg::dprf_state_t state;
    logic                  eoi;
    logic                  background_diag_mode;
    logic                  frag4;
    logic                  mute;
    logic                  src;
    logic [3:0]            paddr;
    dprf_pkg::dprf_src_t   src0;
    dprf_pkg::dprf_src_t   src1;
    logic [1:0][1:0]       keep_alive_counter;
    logic [31:0]           asm_word;
    logic [5:0]            asm_cnt;
    logic                  pend;
    logic                  latched;
    logic [3:0]            left;
    logic [31:0]           dword;
    logic [3:0]            status;
    logic [19:0]           msg;
    logic [4:0]            len;
    logic [7:0]            seed;
    logic                  go;
    logic                  fvld;
    logic [27:0]           frame;
    logic [4:0]            flen;
    logic                  dvld;
    logic [7:0]            dfrag;
    logic                  cvld;
    logic [31:0]           cword;
    logic                  ack;
    logic [31:0]           rdat;
  } dprf_top_st_t;

  dprf_top_st_t st_ff;
  dprf_top_st_t nxt_st;
  dprf_crc_if   crc_if ();

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] dprf_crc(input logic [23:0] d, input logic [4:0] nb,
                                          input logic [7:0] seed);
    logic [7:0] c;
    logic       b;
    c = seed;
    for (int i = 0; i < 32; i++) begin
      if (i >= 24 || (23 - i) < nb) begin
        b = (i < 24) ? d[23 - i] : 1'b0;
        c = {c[6:0], b} ^ (c[7] ? `DPRF_POLY : 8'h00);
      end
    end
    return c;
  endfunction : dprf_crc

  function automatic logic [31:0] dprf_wmask(input logic [31:0] o, input logic [31:0] w,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = w[8*i +: 8];
      end
    end
    return r;
  endfunction : dprf_wmask

  function automatic logic [3:0] dprf_prio(input logic [14:0] f);
    logic [3:0] c;
    c = `DPRF_S_NORMAL;
    // walk from lowest to highest priority so the last hit wins
    if (f[0])  c = `DPRF_S_UNLOCK;
    if (f[1])  c = `DPRF_S_SELFT;
    if (f[2])  c = `DPRF_S_OSC;
    if (f[3])  c = `DPRF_S_PRESS;
    if (f[4])  c = `DPRF_S_TEMP;
    if (f[5])  c = `DPRF_S_UOTP;
    if (f[6])  c = `DPRF_S_URW;
    if (f[7])  c = `DPRF_S_FOTP;
    if (f[8])  c = `DPRF_S_TEST;
    if (f[9])  c = `DPRF_S_SUPPLY;
    if (f[10]) c = `DPRF_S_RESET;
    return c;
  endfunction : dprf_prio

  logic [14:0]         flags;
  logic [3:0]          code;
  logic                is_bcast;
  logic                is_frag;
  logic                mute_now;
  dprf_pkg::dprf_src_t cur;
  logic [1:0]          kac_sel;

  assign flags = {4'h0, reset_occurred_flag, device_status_supply, test_mode_active,
                  factory_otp_error, user_rw_error, user_otp_error, temperature_error,
                  pressure_over_range | pressure_under_range | pressure_redundancy_mismatch,
                  device_status_osc, selftest_incomplete | selftest_running | selftest_fault,
                  user_array_unlocked};
  assign code     = dprf_prio(flags);
  assign is_bcast = cmd_len == `DPRF_LEN_BCAST;
  assign is_frag  = st_ff.background_diag_mode && (st_ff.frag4 ? cmd_len == `DPRF_LEN_F4
                                               : cmd_len == `DPRF_LEN_F2);
  assign mute_now = st_ff.mute && code == `DPRF_S_SUPPLY;
  assign cur      = st_ff.src ? st_ff.src1 : st_ff.src0;
  assign kac_sel  = st_ff.keep_alive_counter[st_ff.src];

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [31:0] rd;
    logic [31:0] wv;
    logic [31:0] w;
    logic [19:0] m;
    logic [4:0]  n;
    logic [9:0]  dat;
    logic [5:0]  cnt;
    rd = 32'h0;
    wv = 32'h0;
    w = 32'h0;
    m = 20'h0;
    n = 5'h0;
    dat = 10'h0;
    cnt = 6'h0;
    nxt_st      = st_ff;
    nxt_st.go   = 1'b0;
    nxt_st.fvld = 1'b0;
    nxt_st.dvld = 1'b0;
    nxt_st.cvld = 1'b0;
    nxt_st.ack  = 1'b0;

    // wishbone slave, one wait state, unmapped reads zero
    case (wb_adr_i)
      `DPRF_A_CTRL: begin
        rd[`DPRF_C_EOI]               = st_ff.eoi;
        rd[`DPRF_C_BDM]               = st_ff.background_diag_mode;
        rd[`DPRF_C_FRAG4]             = st_ff.frag4;
        rd[`DPRF_C_MUTE]              = st_ff.mute;
        rd[`DPRF_C_SRC]               = st_ff.src;
        rd[`DPRF_C_PA_HI:`DPRF_C_PA_LO] = st_ff.paddr;
      end
      `DPRF_A_SRC0: rd[`DPRF_SRC_HI:0] = st_ff.src0;
      `DPRF_A_SRC1: rd[`DPRF_SRC_HI:0] = st_ff.src1;
      `DPRF_A_STAT: rd = {17'h0, st_ff.asm_cnt, st_ff.pend, st_ff.keep_alive_counter, st_ff.status};
      `DPRF_A_DCMD: rd = st_ff.cword;
      default:      rd = 32'h0;
    endcase
    if (wb_cyc_i && wb_stb_i && !st_ff.ack) begin
      nxt_st.ack  = 1'b1;
      nxt_st.rdat = rd;
      wv = dprf_wmask(rd, wb_dat_i, wb_sel_i);
      if (wb_we_i) begin
        case (wb_adr_i)
          `DPRF_A_CTRL: begin
            // the lock bit only sets; software cannot leave collection mode
            nxt_st.eoi   = st_ff.eoi | wv[`DPRF_C_EOI];
            nxt_st.background_diag_mode   = wv[`DPRF_C_BDM];
            nxt_st.frag4 = wv[`DPRF_C_FRAG4];
            nxt_st.mute  = wv[`DPRF_C_MUTE];
            nxt_st.src   = wv[`DPRF_C_SRC];
            nxt_st.paddr = wv[`DPRF_C_PA_HI:`DPRF_C_PA_LO];
          end
          `DPRF_A_SRC0: nxt_st.src0 = dprf_pkg::dprf_src_t'(wv[`DPRF_SRC_HI:0]);
          `DPRF_A_SRC1: nxt_st.src1 = dprf_pkg::dprf_src_t'(wv[`DPRF_SRC_HI:0]);
          default: ;
        endcase
      end
    end

    // ----------------------------------------
    // command reception
    // ----------------------------------------
    if (cmd_valid && st_ff.eoi) begin
      if (st_ff.background_diag_mode) begin
        if (is_bcast) begin
          nxt_st.asm_cnt  = 6'h0;
          nxt_st.asm_word = 32'h0;
          if (st_ff.pend) begin
            // answer data is frozen at the first read of the answer
            w = st_ff.latched ? st_ff.dword : diag_resp_word;
            nxt_st.latched = 1'b1;
            nxt_st.dvld    = 1'b1;
            nxt_st.dfrag   = st_ff.frag4 ? w[31:24] : {4'h0, w[31:28]};
            nxt_st.dword   = st_ff.frag4 ? {w[23:0], 8'h00} : {w[27:0], 4'h0};
            nxt_st.left    = st_ff.left - 4'h1;
            if (st_ff.left == 4'h1) begin
              nxt_st.pend = 1'b0;
            end
          end
        end else if (is_frag) begin
          nxt_st.pend = 1'b0;
          w   = st_ff.frag4 ? {st_ff.asm_word[27:0], cmd_bits}
                            : {st_ff.asm_word[29:0], cmd_bits[1:0]};
          cnt = st_ff.asm_cnt + (st_ff.frag4 ? `DPRF_LEN_F4 : `DPRF_LEN_F2);
          nxt_st.asm_word = w;
          nxt_st.asm_cnt  = cnt;
          if (cnt == `DPRF_CMD_BITS) begin
            nxt_st.asm_cnt = 6'h0;
            if ((w[31:28] == st_ff.paddr || w[31:28] == `DPRF_PA_GLOBAL)
                && w[27:24] == `DPRF_CMD_READ
                && w[7:0] == dprf_crc(w[31:8], `DPRF_CMD_W, `DPRF_CRM_SEED)) begin
              nxt_st.cvld    = 1'b1;
              nxt_st.cword   = w;
              nxt_st.pend    = 1'b1;
              nxt_st.latched = 1'b0;
              nxt_st.left    = st_ff.frag4 ? `DPRF_READS_F4 : `DPRF_READS_F2;
            end
          end
        end else begin
          // any other length ends both the assembly and a running answer
          nxt_st.asm_cnt  = 6'h0;
          nxt_st.asm_word = 32'h0;
          nxt_st.pend     = 1'b0;
        end
      end

      // ----------------------------------------
      // periodic frame build
      // ----------------------------------------
      // a trigger while the crc is still running is dropped; the bus
      // spaces commands far wider than one crc pass
      if (st_ff.state == dprf_pkg::DPRF_IDLE && (is_bcast || is_frag)
          && !mute_now) begin
        dat = cur.dsel ? temperature_data : pressure_data;
        if (code[3] || (!cur.fmt[2] && code != `DPRF_S_NORMAL)) begin
          dat = (st_ff.src0.signed_en || st_ff.src1.signed_en)
                ? `DPRF_ERR_SGN : `DPRF_ERR_UNS;
        end
        if (cur.fmt[0]) begin
          m = {m[15:0], cur.ident};
          n = n + `DPRF_W_ID;
        end
        if (cur.fmt[1]) begin
          m = {m[17:0], kac_sel};
          n = n + `DPRF_W_KAC;
        end
        if (cur.fmt[2]) begin
          m = {m[15:0], code};
          n = n + `DPRF_W_ST;
        end
        m = {m[9:0], dat};
        n = n + `DPRF_W_DAT;
        nxt_st.keep_alive_counter[st_ff.src] = kac_sel + 2'h1;
        nxt_st.msg    = m;
        nxt_st.len    = n;
        nxt_st.seed   = {4'h0, cur.ident};
        nxt_st.status = code;
        nxt_st.go     = 1'b1;
        nxt_st.state  = dprf_pkg::DPRF_CRC;
      end
    end

    case (st_ff.state)
      dprf_pkg::DPRF_IDLE: ;
      dprf_pkg::DPRF_CRC: begin
        if (crc_if.done) begin
          nxt_st.fvld  = 1'b1;
          nxt_st.frame = {st_ff.msg, crc_if.crc};
          nxt_st.flen  = st_ff.len + `DPRF_W_CRC;
          nxt_st.state = dprf_pkg::DPRF_IDLE;
        end
      end
      default: nxt_st.state = dprf_pkg::DPRF_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // crc engine and outputs
  // ----------------------------------------
  assign crc_if.go   = st_ff.go;
  assign crc_if.msg  = st_ff.msg << (`DPRF_MSG_W - st_ff.len);
  assign crc_if.len  = st_ff.len;
  assign crc_if.seed = st_ff.seed;

  dprf_crc_unit u_crc (
    .mclk    (mclk),
    .reset_n (reset_n),
    .ce      (ce),
    .cif     (crc_if.eng)
  );

  assign wb_dat_o                 = st_ff.rdat;
  assign wb_ack_o                 = st_ff.ack;
  assign frame_valid              = st_ff.fvld;
  assign frame_data               = st_ff.frame;
  assign frame_len                = st_ff.flen;
  assign diag_frag_valid          = st_ff.dvld;
  assign diag_frag                = st_ff.dfrag;
  assign diag_cmd_valid           = st_ff.cvld;
  assign diag_cmd_word            = st_ff.cword;
  assign periodic_collection_mode = st_ff.eoi;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  logic trig;
  assign trig = ce && st_ff.state == dprf_pkg::DPRF_IDLE && nxt_st.state == dprf_pkg::DPRF_CRC;

  property p_no_init;
    ce && cmd_valid && !st_ff.eoi && st_ff.state == dprf_pkg::DPRF_IDLE
      |=> st_ff.state == dprf_pkg::DPRF_IDLE && !st_ff.cvld;
  endproperty
  a_no_init: assert property (p_no_init) else $error("answer before init");

  property p_bcast;
    ce && cmd_valid && is_bcast && st_ff.eoi && !mute_now
      && st_ff.state == dprf_pkg::DPRF_IDLE |=> st_ff.state == dprf_pkg::DPRF_CRC;
  endproperty
  a_bcast: assert property (p_bcast) else $error("read not answered");

  property p_only;
    ce && cmd_valid && !is_bcast && !is_frag && st_ff.state == dprf_pkg::DPRF_IDLE
      |=> st_ff.state == dprf_pkg::DPRF_IDLE;
  endproperty
  a_only: assert property (p_only) else $error("answered a bad command");

  property p_clear;
    ce && cmd_valid && st_ff.eoi && st_ff.background_diag_mode && !is_frag |=> st_ff.asm_cnt == 6'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("assembly kept");

  property p_cmd_ok;
    st_ff.cvld |-> st_ff.cword[7:0]
      == dprf_crc(st_ff.cword[31:8], `DPRF_CMD_W, `DPRF_CRM_SEED) && $past(st_ff.background_diag_mode);
  endproperty
  a_cmd_ok: assert property (p_cmd_ok) else $error("bad diag command taken");

  property p_kac;
    trig |=> st_ff.keep_alive_counter[$past(st_ff.src)] == $past(kac_sel) + 2'h1;
  endproperty
  a_kac: assert property (p_kac) else $error("keep-alive not advanced");

  property p_crc;
    st_ff.fvld |-> st_ff.frame[7:0] == dprf_crc({4'h0, st_ff.frame[27:8]},
                                                 st_ff.flen - `DPRF_W_CRC, st_ff.seed);
  endproperty
  a_crc: assert property (p_crc) else $error("frame crc wrong");

  property p_prio;
    trig && reset_occurred_flag |=> st_ff.status == `DPRF_S_RESET;
  endproperty
  a_prio: assert property (p_prio) else $error("priority wrong");

  property p_left;
    ce && cmd_valid && st_ff.eoi && st_ff.background_diag_mode && is_bcast && st_ff.pend
      |=> st_ff.dvld && st_ff.left == $past(st_ff.left) - 4'h1;
  endproperty
  a_left: assert property (p_left) else $error("too many reads");

  c_frame: cover property (st_ff.fvld);
  c_dcmd:  cover property (st_ff.cvld);
  c_dfrag: cover property (st_ff.dvld && !st_ff.pend);
  c_mute:  cover property (ce && cmd_valid && st_ff.eoi && mute_now);
endmodule : dprf_top
`default_nettype wire

/* dv/dprf_master_model.sv */
`timescale 1ns/10ps
`default_nettype none
module dprf_master_model (
  input  wire logic       mclk,
  output logic            cmd_valid,
  output logic      [5:0] cmd_len,
  output logic      [3:0] cmd_bits
);
  initial cmd_valid = 1'b0;
  initial cmd_len = 6'h00;
  initial cmd_bits = 4'h0;
  // bits go inverted after the pulse so a stale value never reads as a new command
  task automatic send(input logic [5:0] len, input logic [3:0] bits);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_len   <= len;
    cmd_bits  <= bits;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    cmd_bits  <= ~bits;
  endtask : send
endmodule : dprf_master_model
`default_nettype wire

/* dv/dprf_top_test.sv */
`timescale 1ns/10ps
`default_nettype none
module dprf_top_test;
  logic mclk = 1'b0, reset_n = 1'b0, ce = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0, wb_ack_o, cmd_valid, frame_valid, diag_frag_valid, diag_cmd_valid;
  logic periodic_collection_mode;
  logic [7:0] wb_adr_i = 8'h00, diag_frag;
  logic [3:0] wb_sel_i = 4'h0, cmd_bits;
  logic [5:0] cmd_len;
  logic [4:0] frame_len;
  logic [9:0] pressure_data = 10'h000, temperature_data = 10'h2A5;
  logic [14:0] sv = 15'h0000;
  logic [27:0] frame_data;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, diag_cmd_word, w, v, rd;
  logic [31:0] diag_resp_word = 32'hA5C30F96;
  logic [1:0] k = 2'h0;
  logic [7:0] fq[$];
  int error_cnt = 0, checks = 0, dcn = 0;
  localparam logic [14:0] rs [16] = '{15'h0001, 15'h0002, 15'h0004, 15'h0000, 15'h0008,
    15'h0010, 15'h0020, 15'h0080, 15'h0100, 15'h0200, 15'h0400, 15'h0800, 15'h1000,
    15'h2000, 15'h4001, 15'h0130};
  localparam logic [3:0] rx [16] = '{4'h1, 4'h2, 4'h2, 4'h0, 4'h2, 4'h3, 4'h4, 4'h4,
    4'h5, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'h5};
  always #12.5 mclk = ~mclk;
  dprf_master_model u_dprf_master_model (.mclk(mclk), .cmd_valid(cmd_valid),
    .cmd_len(cmd_len), .cmd_bits(cmd_bits));
  dprf_top u_dprf_top (.mclk(mclk), .reset_n(reset_n), .ce(ce), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmd_valid(cmd_valid),
    .cmd_len(cmd_len), .cmd_bits(cmd_bits), .pressure_data(pressure_data),
    .temperature_data(temperature_data), .user_array_unlocked(sv[0]),
    .selftest_incomplete(sv[1]), .selftest_running(sv[2]), .selftest_fault(sv[3]),
    .device_status_osc(sv[4]), .pressure_over_range(sv[5]), .pressure_under_range(sv[6]),
    .pressure_redundancy_mismatch(sv[7]), .temperature_error(sv[8]), .user_otp_error(sv[9]),
    .user_rw_error(sv[10]), .factory_otp_error(sv[11]), .test_mode_active(sv[12]),
    .device_status_supply(sv[13]), .reset_occurred_flag(sv[14]),
    .diag_resp_word(diag_resp_word), .frame_valid(frame_valid), .frame_data(frame_data),
    .frame_len(frame_len), .diag_frag_valid(diag_frag_valid), .diag_frag(diag_frag),
    .diag_cmd_valid(diag_cmd_valid), .diag_cmd_word(diag_cmd_word),
    .periodic_collection_mode(periodic_collection_mode));
  // pulses are gone long before a frame arrives, so catch them here
  always @(posedge mclk) begin
    if (diag_cmd_valid === 1'b1) dcn <= dcn + 1;
    if (diag_frag_valid === 1'b1) fq.push_back(diag_frag);
  end
  function automatic logic [7:0] crc8(input logic [23:0] m, input int n, input logic [7:0] s);
    logic [7:0] r;
    r = s;
    for (int i = n + 7; i >= 0; i--) begin
      r = {r[6:0], (i >= 8) ? m[i-8] : 1'b0} ^ (r[7] ? 8'h2F : 8'h00);
    end
    return r;
  endfunction : crc8
  function automatic logic [27:0] ex(input logic [3:0] st, input logic [9:0] d);
    return {4'h1, k, st, d, crc8({4'h1, k, st, d}, 20, 8'h01)};
  endfunction : ex
  task automatic ck(input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (e !== g) begin
      error_cnt++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : ck
  task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic we);
    int n;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    n = 0;
    do begin @(posedge mclk); n++; end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    ck(32'h0, {31'h0, n >= 20});
  endtask : wb
  task automatic fr(input logic [5:0] cl, input logic [3:0] cb, input logic [4:0] l,
                    input logic [27:0] e);
    int n;
    u_dprf_master_model.send(cl, cb);
    n = 0;
    do begin @(posedge mclk); n++; end while (frame_valid !== 1'b1 && n < 50);
    ck({31'h0, l != 5'h00}, {31'h0, n < 50});
    if (l != 5'h00) begin
      ck({4'h0, e}, {4'h0, frame_data});
      ck({27'h0, l}, {27'h0, frame_len});
      k = k + 2'h1;
    end
    repeat (2) @(posedge mclk);
  endtask : fr
  task automatic final_report;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  initial begin
    #500000;
    error_cnt++;
    final_report;
  end
  initial begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    wb(8'h00, 32'h0, 1'b0);
    ck(32'h0, rd);
    fr(6'h01, 4'h1, 5'h00, 28'h0);
    wb(8'h04, 32'h71, 1'b1);
    wb(8'h00, 32'h1, 1'b1);
    wb(8'h00, 32'h0, 1'b1);
    wb(8'h00, 32'h0, 1'b0);
    ck(32'h1, rd);
    ck(32'h1, {31'h0, periodic_collection_mode});
    wb(8'h20, 32'hFFFFFFFF, 1'b1);
    wb(8'h20, 32'h0, 1'b0);
    ck(32'h0, rd);
    fr(6'h02, 4'h3, 5'h00, 28'h0);
    for (int i = 0; i < 16; i++) begin
      sv <= rs[i];
      pressure_data <= 10'h1FC + 10'(i);
      @(posedge mclk);
      fr(6'h01, 4'(i), 5'h1C, ex(rx[i], rx[i][3] ? 10'h3FF : pressure_data));
      if (i == 3) ck(32'hD6, {24'h0, frame_data[7:0]});
    end
    wb(8'h08, 32'h100, 1'b1);
    sv <= 15'h0200;
    fr(6'h01, 4'h0, 5'h1C, ex(4'h8, 10'h200));
    wb(8'h08, 32'h0, 1'b1);
    wb(8'h04, 32'hF1, 1'b1);
    sv <= 15'h0000;
    fr(6'h01, 4'h1, 5'h1C, ex(4'h0, 10'h2A5));
    wb(8'h04, 32'h31, 1'b1);
    sv <= 15'h0001;
    fr(6'h01, 4'h0, 5'h18, {4'h0,4'h1,k,10'h3FF,crc8({4'h1,k,10'h3FF},16,8'h01)});
    wb(8'h04, 32'h71, 1'b1);
    wb(8'h00, 32'h9, 1'b1);
    sv <= 15'h2000;
    fr(6'h01, 4'h1, 5'h00, 28'h0);
    wb(8'h00, 32'h7, 1'b1);
    sv <= 15'h0000;
    w = {8'h00, 16'h1234, crc8({8'h00, 16'h1234}, 24, 8'h00)};
    for (int j = 0; j < 3; j++) fr(6'h04, 4'hF, 5'h1C, ex(4'h0, pressure_data));
    fr(6'h01, 4'h0, 5'h1C, ex(4'h0, pressure_data));
    fr(6'h03, 4'h0, 5'h00, 28'h0);
    // a corrupted word first, so acceptance is seen to depend on the check
    for (int t = 0; t < 2; t++) begin
      v = (t == 0) ? w ^ 32'h100 : w;
      for (int j = 7; j >= 0; j--) begin
        fr(6'h04, v[j*4+:4], 5'h1C, ex(4'h0, pressure_data));
      end
      ck(32'(t), 32'(dcn));
      if (t == 0) fr(6'h01, 4'h1, 5'h1C, ex(4'h0, pressure_data));
    end
    ck(w, diag_cmd_word);
    for (int j = 0; j < 4; j++) fr(6'h01, 4'h0, 5'h1C, ex(4'h0, pressure_data));
    ck(32'h4, 32'(fq.size()));
    for (int j = 0; j < 4; j++) ck({24'h0, diag_resp_word[31-8*j-:8]}, {24'h0, fq[j]});
    // two-bit fragments: sixteen pieces in, eight nibble answers out
    wb(8'h00, 32'h3, 1'b1);
    for (int j = 15; j >= 0; j--) begin
      fr(6'h02, {2'h0, w[j*2+:2]}, 5'h1C, ex(4'h0, pressure_data));
    end
    ck(32'h2, 32'(dcn));
    for (int j = 0; j < 8; j++) begin
      fr(6'h01, 4'h0, 5'h1C, ex(4'h0, pressure_data));
    end
    ck(32'hC, 32'(fq.size()));
    for (int j = 0; j < 8; j++) begin
      ck({28'h0, diag_resp_word[31-4*j-:4]}, {24'h0, fq[4+j]});
    end
    // clock enable low holds the crc pass, so the frame comes late
    u_dprf_master_model.send(6'h01, 4'h0);
    ce <= 1'b0;
    repeat (40) @(posedge mclk);
    ck(32'h0, {31'h0, frame_valid});
    ce <= 1'b1;
    repeat (31) @(posedge mclk);
    ck(32'h1, {31'h0, frame_valid});
    ck({4'h0, ex(4'h0, pressure_data)}, {4'h0, frame_data});
    k = k + 2'h1;
    // reset in mid-run clears the lock bit and the counters
    reset_n <= 1'b0;
    @(posedge mclk);
    reset_n <= 1'b1;
    ck(32'h0, {31'h0, periodic_collection_mode});
    wb(8'h0C, 32'h0, 1'b0);
    ck(32'h0, rd);
    wb(8'h00, 32'h11, 1'b1);
    fr(6'h01, 4'h0, 5'h12, {10'h0, pressure_data, crc8({14'h0, pressure_data}, 10, 8'h00)});
    final_report;
  end
endmodule : dprf_top_test
`default_nettype wire
